/* mmsc_ctrl.sv */
`timescale 1ns/100ps
module mmsc_ctrl
  import mmsc_pkg::*;
(
  input wire logic ref_clk_in, // 40 MHz system clock
  input wire logic rst_n_in, // synchronous power-on reset, active low
  input wire logic init_n_in, // init pin, low selects init mode
  input wire logic init_sw_in, // rear switch, high in init position
  input wire logic heartbeat_in, // firmware alive pulse
  input wire logic cmd_valid_in, // one-cycle command received
  input wire mmsc_cmd_t cmd_in, // decoded command
  input wire logic [7:0] cmd_func_in, // modbus function code
  input wire logic [7:0] cmd_sub_in, // modbus sub-function
  input wire logic [7:0] cmd_arg_in, // new type code or address
  input wire logic [3:0] cmd_baud_in, // new baud code
  input wire logic cmd_cksum_in, // new checksum enable
  input wire logic cmd_proto_in, // new protocol select
  input wire logic [7:0] cmd_fmt_in, // new data format
  input wire logic resp_done_in, // one-cycle response sent
  input wire logic [7:0] nv_addr_in, // stored address
  input wire logic [7:0] nv_type_in, // stored type code
  input wire logic [3:0] nv_baud_in, // stored baud code
  input wire logic nv_cksum_in, // stored checksum enable
  input wire logic nv_proto_in, // stored protocol
  input wire logic [15:0] fact_cal_in, // factory calibration word
  input wire logic [7:0] wdt_steps_in, // host timeout, 100 ms steps
  input wire logic wdt_en_in, // host watchdog enable
  input wire logic [3:0] do_safe_in, // safe output value
  input wire logic [3:0] do_pon_in, // power-on output value
  input wire logic use_safe_in, // load safe value after reset
  input wire logic [3:0] do_req_in, // output value from host
  input wire logic do_wr_in, // one-cycle output write
  input wire logic signed [31:0] raw_in, // scaled reading
  output logic [15:0] eng_out, // engineering-unit word
  output logic led_out, // power led, high lit
  output logic init_mode_out, // init mode latched at power-on
  output logic [7:0] addr_out, // active address
  output logic [7:0] type_out, // active type code
  output logic [7:0] fmt_out, // active data format
  output logic [3:0] baud_out, // active baud code
  output logic cksum_out, // active checksum enable
  output logic proto_out, // active protocol
  output logic [15:0] cal_out, // active calibration word
  output logic rst_flag_out, // reset-status flag
  output logic rst_resp_out, // flag value reported in response
  output logic wdt_to_out, // host watchdog timed out
  output logic [3:0] do_out, // digital outputs
  output logic sup_rst_out // supervisor reset pulse
);
  logic init_a_q; // init pin, first stage
  logic init_b_q; // init pin, synchronised
  logic sw_a_q; // rear switch, first stage
  logic sw_b_q; // rear switch, synchronised
  logic hb_a_q; // heartbeat, first stage
  logic hb_b_q; // heartbeat, synchronised
  logic boot_q; // first cycle after reset
  logic ld_q; // config load cycle
  logic pend_q; // flag clear waits for response
  logic busy_q; // command in progress
  logic [31:0] sup_cnt_q; // supervisor idle cycles
  logic [31:0] step_cnt_q; // cycles within a 100 ms step
  logic [7:0] wdt_cnt_q; // elapsed host timeout steps
  logic [15:0] raw_lo_q; // low word of the last reading
  logic [31:0] range_w; // {low, high} for the active type
  logic signed [15:0] lo_w; // low full scale
  logic signed [15:0] hi_w; // high full scale
  logic in_init_w; // init mode requested by pins
  logic under_w; // reading below range
  logic over_w; // reading above range
  logic cfg_ok_w; // locked command allowed
  logic type_ok_w; // type code change accepted
  logic step_w; // 100 ms enable pulse
  logic to_w; // host timeout reached
  logic sup_end_w; // supervisor about to expire

  // input synchronisers
  always_ff @(posedge ref_clk_in) begin
    init_a_q <= init_n_in;
    init_b_q <= init_a_q;
    sw_a_q <= init_sw_in;
    sw_b_q <= sw_a_q;
    hb_a_q <= heartbeat_in;
    hb_b_q <= hb_a_q;
  end

  // range and command decode
  assign range_w = mmsc_range(type_out);
  assign lo_w = signed'(range_w[31:16]);
  assign hi_w = signed'(range_w[15:0]);
  assign under_w = raw_in < 32'(lo_w);
  assign over_w = raw_in > 32'(hi_w);
  assign in_init_w = !init_b_q || sw_b_q;
  assign cfg_ok_w = cmd_valid_in && init_mode_out;
  assign type_ok_w = cmd_valid_in && ((cmd_in == MMSC_CMD_CHAN_TYPE) ||
    (cmd_in == MMSC_CMD_MODBUS && cmd_func_in == MB_FUNC_CFG &&
     cmd_sub_in == MB_SUB_TYPE));
  assign step_w = step_cnt_q == STEP_CYC - 1;
  assign to_w = wdt_en_in && step_w && (wdt_cnt_q + 8'h01 >= wdt_steps_in);
  assign sup_end_w = sup_cnt_q == 32'(SUP_CYC - 2);

  // engineering-unit clamp, two's complement
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) eng_out <= 16'h0000;
    else if (under_w) eng_out <= UNDER_CODE;
    else if (over_w) eng_out <= OVER_CODE;
    else eng_out <= raw_in[15:0];
  end

  // low word kept for the pass-through check
  always_ff @(posedge ref_clk_in) begin
    raw_lo_q <= raw_in[15:0];
  end

  // module supervisor: times out without heartbeat
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || hb_b_q || sup_rst_out) sup_cnt_q <= 32'h0;
    else sup_cnt_q <= sup_cnt_q + 32'h1;
  end

  // registered expiry pulse, one cycle long
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || hb_b_q || sup_rst_out) sup_rst_out <= 1'b0;
    else sup_rst_out <= sup_end_w;
  end

  // boot: latch init mode then load config on next edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sup_rst_out) begin
      boot_q <= 1'b1;
      ld_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      ld_q <= boot_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) init_mode_out <= 1'b0;
    else if (boot_q) init_mode_out <= in_init_w;
  end

  // active configuration
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      addr_out <= INIT_ADDR;
      baud_out <= INIT_BAUD;
      cksum_out <= INIT_CKSUM;
      proto_out <= INIT_PROTO;
      type_out <= 8'h00;
      fmt_out <= 8'h00;
    end else if (ld_q) begin
      type_out <= nv_type_in;
      addr_out <= init_mode_out ? INIT_ADDR : nv_addr_in;
      baud_out <= init_mode_out ? INIT_BAUD : nv_baud_in;
      cksum_out <= init_mode_out ? INIT_CKSUM : nv_cksum_in;
      proto_out <= init_mode_out ? INIT_PROTO : nv_proto_in;
    end else begin
      if (type_ok_w) type_out <= cmd_arg_in;
      if (cmd_valid_in && cmd_in == MMSC_CMD_CFG_SET) begin
        fmt_out <= cmd_fmt_in;
        if (!init_mode_out) addr_out <= cmd_arg_in;
      end
      if (cfg_ok_w && cmd_in == MMSC_CMD_CFG_SET) begin
        baud_out <= cmd_baud_in;
        cksum_out <= cmd_cksum_in;
      end
      if (cfg_ok_w && cmd_in == MMSC_CMD_PROTO_SEL) proto_out <= cmd_proto_in;
    end
  end

  // calibration reload
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || ld_q) cal_out <= fact_cal_in;
    else if (cmd_valid_in && cmd_in == MMSC_CMD_CAL_RELOAD) cal_out <= fact_cal_in;
  end

  // led: off on command, on after response
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      led_out <= 1'b1;
      busy_q <= 1'b0;
    end else if (resp_done_in) begin
      led_out <= 1'b1;
      busy_q <= 1'b0;
    end else if (cmd_valid_in) begin
      led_out <= 1'b0;
      busy_q <= 1'b1;
    end
  end

  // reset-status flag with pending clear after query response
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sup_rst_out) begin
      rst_flag_out <= 1'b1;
      pend_q <= 1'b0;
      rst_resp_out <= 1'b0;
    end else if (cmd_valid_in && cmd_in == MMSC_CMD_RST_QUERY) begin
      rst_resp_out <= rst_flag_out;
      pend_q <= 1'b1;
    end else if (resp_done_in && pend_q) begin
      rst_flag_out <= 1'b0;
      pend_q <= 1'b0;
    end
  end

  // host watchdog in 100 ms steps
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || cmd_valid_in || !wdt_en_in || step_w) step_cnt_q <= 32'h0;
    else step_cnt_q <= step_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || cmd_valid_in || !wdt_en_in) wdt_cnt_q <= 8'h00;
    else if (step_w && wdt_cnt_q != 8'hFF) wdt_cnt_q <= wdt_cnt_q + 8'h01;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !wdt_en_in) wdt_to_out <= 1'b0;
    else if (to_w) wdt_to_out <= 1'b1;
    else if (cmd_valid_in) wdt_to_out <= 1'b0;
  end

  // digital outputs
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) do_out <= 4'h0;
    else if (ld_q) do_out <= use_safe_in ? do_safe_in : do_pon_in;
    else if (to_w || wdt_to_out) do_out <= do_safe_in;
    else if (do_wr_in) do_out <= do_req_in;
  end

  // checks share the system clock and the reset
  default clocking a_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // power led follows command and response
  a_led_cmd_off: assert property (
    cmd_valid_in && !resp_done_in |=> !led_out)
    else $error("led not off");
  a_led_resp_on: assert property (
    resp_done_in |=> led_out)
    else $error("led not on");
  a_led_busy: assert property (
    busy_q |-> !led_out)
    else $error("led lit while busy");

  // engineering-unit clamp
  a_under_code: assert property (
    under_w |=> eng_out == UNDER_CODE)
    else $error("under code");
  a_over_code: assert property (
    over_w && !under_w |=> eng_out == OVER_CODE)
    else $error("over code");
  a_eng_pass: assert property (
    !under_w && !over_w |=> eng_out == raw_lo_q)
    else $error("reading not passed");

  // boot and configuration load
  a_init_latch: assert property (
    boot_q |=> init_mode_out == $past(in_init_w))
    else $error("init mode not latched");
  a_init_defaults: assert property (
    ld_q && init_mode_out |=> addr_out == INIT_ADDR && baud_out == INIT_BAUD)
    else $error("init defaults");
  a_init_proto: assert property (
    ld_q && init_mode_out |=> cksum_out == INIT_CKSUM && proto_out == INIT_PROTO)
    else $error("init protocol");
  a_nv_defaults: assert property (
    ld_q && !init_mode_out |=> addr_out == $past(nv_addr_in) && baud_out == $past(nv_baud_in))
    else $error("stored config not loaded");
  a_do_load: assert property (
    ld_q |=> do_out == ($past(use_safe_in) ? $past(do_safe_in) : $past(do_pon_in)))
    else $error("outputs not loaded");

  // locked settings outside init mode
  a_proto_locked: assert property (
    !init_mode_out && !ld_q |=> $stable(proto_out))
    else $error("proto changed");
  a_baud_locked: assert property (
    !init_mode_out && !ld_q |=> $stable(baud_out))
    else $error("baud changed");
  a_cksum_locked: assert property (
    !init_mode_out && !ld_q |=> $stable(cksum_out))
    else $error("checksum changed");

  // type code and calibration commands
  a_type_cmd: assert property (
    type_ok_w && !ld_q |=> type_out == $past(cmd_arg_in))
    else $error("type not taken");
  a_cal_reload: assert property (
    cmd_valid_in && cmd_in == MMSC_CMD_CAL_RELOAD |=> cal_out == $past(fact_cal_in))
    else $error("calibration not reloaded");

  // reset-status flag
  a_flag_clear: assert property (
    resp_done_in && pend_q && !sup_rst_out && !cmd_valid_in |=> !rst_flag_out)
    else $error("flag kept");
  a_resp_value: assert property (
    cmd_valid_in && cmd_in == MMSC_CMD_RST_QUERY && !sup_rst_out |=> rst_resp_out == $past(rst_flag_out))
    else $error("wrong flag reported");
  a_flag_steady: assert property (
    !sup_rst_out && !(resp_done_in && pend_q) |=> $stable(rst_flag_out))
    else $error("flag moved");
  a_flag_set: assert property (
    sup_rst_out |=> rst_flag_out)
    else $error("flag not set");

  // watchdogs
  a_safe_hold: assert property (
    wdt_to_out && !ld_q |=> do_out == $past(do_safe_in))
    else $error("not safe");
  a_wdt_off: assert property (
    !wdt_en_in |=> !wdt_to_out)
    else $error("timeout while disabled");
  a_step_bound: assert property (
    step_cnt_q < 32'(STEP_CYC))
    else $error("step counter overrun");
  a_sup_pulse: assert property (
    sup_rst_out |=> !sup_rst_out)
    else $error("supervisor pulse too long");

  // main scenarios
  c_cmd_resp: cover property (cmd_valid_in ##[1:20] resp_done_in);
  c_timeout: cover property ($rose(wdt_to_out));
  c_query: cover property ($fell(rst_flag_out));
  c_init_boot: cover property (ld_q && init_mode_out);
  c_under: cover property (under_w);
endmodule : mmsc_ctrl

/* mmsc_host.sv */
`timescale 1ns/100ps
// host side: one command at a time, answer after a chosen gap
module mmsc_host (
  input wire logic ref_clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic go_in, // send one command
  input wire logic [3:0] gap_in, // cycles until the answer
  output logic cmd_valid_out, // command received pulse
  output logic resp_done_out // response sent pulse
);
  logic [3:0] cnt_q;
  logic busy_q;
  // the answer always follows its command, never overlaps the next one
  always_ff @(posedge ref_clk_in) begin
    cmd_valid_out <= rst_n_in & go_in & ~busy_q;
    resp_done_out <= rst_n_in & busy_q & (cnt_q == 4'h0);
    cnt_q <= (go_in && !busy_q) ? gap_in : cnt_q - 4'h1;
    if (!rst_n_in) busy_q <= 1'b0;
    else if (go_in && !busy_q) busy_q <= 1'b1;
    else if (cnt_q == 4'h0) busy_q <= 1'b0;
  end
endmodule : mmsc_host

/* mmsc_pkg.sv */
package mmsc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned STEP_MS = 100;
  localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned SUP_TIMEOUT_MS = 1000;
  localparam int unsigned SUP_CYC = CLK_HZ / 1000 * SUP_TIMEOUT_MS;
  localparam logic [7:0] INIT_ADDR = 8'h00;
  localparam logic [3:0] INIT_BAUD = 4'h6; // 9600 bps baud code
  localparam logic INIT_CKSUM = 1'b0;
  localparam logic INIT_PROTO = 1'b0; // 0 ascii, 1 modbus rtu
  localparam logic [7:0] MB_FUNC_CFG = 8'h46;
  localparam logic [7:0] MB_SUB_TYPE = 8'h08;
  localparam logic [15:0] UNDER_CODE = 16'h8000;
  localparam logic [15:0] OVER_CODE = 16'h7FFF;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'h0000;
  typedef enum logic [2:0] {
    MMSC_CMD_NONE, MMSC_CMD_RST_QUERY, MMSC_CMD_READBACK, MMSC_CMD_CFG_SET,
    MMSC_CMD_PROTO_SEL, MMSC_CMD_CHAN_TYPE, MMSC_CMD_CAL_RELOAD, MMSC_CMD_MODBUS
  } mmsc_cmd_t;
  typedef enum {MMSC_IDLE, MMSC_BUSY} mmsc_state_t;

  // signed full-scale limits for a type code, {low, high}
  function automatic logic [31:0] mmsc_range(input logic [7:0] code);
    case (code)
      8'h07: mmsc_range = {16'sd4000, 16'sd20000};
      8'h08: mmsc_range = {-16'sd10000, 16'sd10000};
      8'h09: mmsc_range = {-16'sd5000, 16'sd5000};
      8'h0A: mmsc_range = {-16'sd10000, 16'sd10000};
      8'h0B: mmsc_range = {-16'sd5000, 16'sd5000};
      8'h0C: mmsc_range = {-16'sd15000, 16'sd15000};
      8'h0D: mmsc_range = {-16'sd20000, 16'sd20000};
      8'h1A: mmsc_range = {16'sd0, 16'sd20000};
      default: mmsc_range = {LOW_RST, HIGH_RST};
    endcase
  endfunction : mmsc_range
endpackage : mmsc_pkg

/* module_mode_status_control_test.sv */
`timescale 1ns/100ps
module module_mode_status_control_test;
  import mmsc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, init_n = 1'b1, init_sw = 1'b0, go = 1'b0;
  logic cv, rd, hb = 1'b0, cks = 1'b0, pro = 1'b0, use_safe = 1'b0;
  logic [1:0] nvcp = 2'b00;
  logic [3:0] gap = 4'h1, baud = 4'h3, nv_baud = 4'h9, dsafe = 4'hA, dpon = 4'h5;
  logic [7:0] func = 8'h46, sub = 8'h08, arg = 8'h00, nv_addr = 8'h00;
  logic [7:0] nv_type = 8'h08, fmt_in = 8'h00, addr, typ, fmt;
  logic [15:0] fcal = 16'h0000, eng, cal;
  logic signed [31:0] raw = 32'sd0;
  logic [31:0] rnd = 32'd80036;
  mmsc_cmd_t cmd = MMSC_CMD_NONE;
  logic led, imode, flag, resp, cko, pro_o, wto, sup, dwr = 1'b0;
  logic [3:0] dreq = 4'h0;
  logic [3:0] bd, dout;
  logic [19:0] n;
  logic [19:0] q[$];
  int mismatches = 0, comparisons = 0;
  logic [7:0] code_t[8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h1A};
  int lo_t[8] = '{4000, -10000, -5000, -10000, -5000, -15000, -20000, 0};
  int hi_t[8] = '{20000, 10000, 5000, 10000, 5000, 15000, 20000, 20000};

  always #12.5 clk = ~clk;

  mmsc_ctrl u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .init_n_in(init_n),
    .init_sw_in(init_sw), .heartbeat_in(hb), .cmd_valid_in(cv), .cmd_in(cmd),
    .cmd_func_in(func), .cmd_sub_in(sub), .cmd_arg_in(arg), .cmd_baud_in(baud),
    .cmd_cksum_in(cks), .cmd_proto_in(pro), .cmd_fmt_in(fmt_in), .resp_done_in(rd),
    .nv_addr_in(nv_addr), .nv_type_in(nv_type), .nv_baud_in(nv_baud),
    .nv_cksum_in(nvcp[1]), .nv_proto_in(nvcp[0]), .fact_cal_in(fcal),
    .wdt_steps_in(8'h00), .wdt_en_in(1'b0), .do_safe_in(dsafe), .do_pon_in(dpon),
    .use_safe_in(use_safe), .do_req_in(dreq), .do_wr_in(dwr), .raw_in(raw),
    .eng_out(eng), .led_out(led), .init_mode_out(imode), .addr_out(addr),
    .type_out(typ), .fmt_out(fmt), .baud_out(bd), .cksum_out(cko), .proto_out(pro_o),
    .cal_out(cal), .rst_flag_out(flag), .rst_resp_out(resp), .wdt_to_out(wto),
    .do_out(dout), .sup_rst_out(sup));
  mmsc_host u_host (.ref_clk_in(clk), .rst_n_in(rst_n), .go_in(go), .gap_in(gap),
    .cmd_valid_out(cv), .resp_done_out(rd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic note(input logic [3:0] s, input logic [15:0] e);
    q.push_back({s, e});
  endtask : note
  task automatic summarize;
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // reset with the mode pins held, then expect the boot state
  task automatic boot(input logic pin, input logic sw, input logic sf);
    rst_n <= 1'b0;
    init_n <= ~pin;
    init_sw <= sw;
    use_safe <= sf;
    nv_addr <= rnd[7:0];
    nvcp <= rnd[9:8];
    fmt_in <= rnd[15:8];
    fcal <= rnd[31:16];
    rnd = lfsr(rnd);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    note(4'h2, 16'h0001);
    note(4'h1, 16'h0001);
    note(4'hA, {15'h0000, pin | sw});
    note(4'h5, (pin | sw) ? 16'h0000 : {8'h00, nv_addr});
    note(4'h6, {12'h000, (pin | sw) ? 4'h6 : nv_baud});
    note(4'h7, {14'h0000, (pin | sw) ? 2'b00 : nvcp});
    note(4'h9, {12'h000, sf ? dsafe : dpon});
    note(4'hC, 16'h0000);
    if (!(pin | sw)) note(4'h4, {8'h00, nv_type});
  endtask : boot
  // one command through the host, led dark until the answer
  task automatic cmdx(input mmsc_cmd_t c, input logic [7:0] a);
    int i;
    cmd <= c;
    arg <= a;
    go <= 1'b1;
    hb <= ~hb;
    gap <= {1'b0, rnd[2:0]} | 4'h1;
    rnd = lfsr(rnd);
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    note(4'h1, 16'h0000);
    for (i = 0; i < 20 && rd !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    note(4'h1, 16'h0001);
  endtask : cmdx
  task automatic eng_chk(input int v, input logic [15:0] e);
    raw <= v;
    @(posedge clk);
    note(4'h0, e);
  endtask : eng_chk

  // every queued note, oldest first, against the settled outputs
  always @(negedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n[19:16])
        4'h0: check(eng, n[15:0]);
        4'h1: check({15'h0000, led}, n[15:0]);
        4'h2: check({15'h0000, flag}, n[15:0]);
        4'h3: check({15'h0000, resp}, n[15:0]);
        4'h4: check({8'h00, typ}, n[15:0]);
        4'h5: check({8'h00, addr}, n[15:0]);
        4'h6: check({12'h000, bd}, n[15:0]);
        4'h7: check({14'h0000, cko, pro_o}, n[15:0]);
        4'h8: check(cal, n[15:0]);
        4'h9: check({12'h000, dout}, n[15:0]);
        4'hA: check({15'h0000, imode}, n[15:0]);
        4'hB: check({8'h00, fmt}, n[15:0]);
        default: check({14'h0000, wto, sup}, n[15:0]);
      endcase
    end
  end

  // main sequence
  initial begin
    int v;
    boot(1'b0, 1'b0, 1'b0);
    cmdx(MMSC_CMD_CHAN_TYPE, 8'h0D);
    note(4'h4, 16'h000D);
    cmdx(MMSC_CMD_RST_QUERY, 8'h00);
    note(4'h3, 16'h0001);
    note(4'h2, 16'h0000);
    cmdx(MMSC_CMD_RST_QUERY, 8'h00);
    note(4'h3, 16'h0000);
    pro <= ~nvcp[0];
    cks <= ~nvcp[1];
    cmdx(MMSC_CMD_PROTO_SEL, 8'h00);
    cmdx(MMSC_CMD_CFG_SET, 8'h21);
    note(4'h7, {14'h0000, nvcp});
    note(4'h6, {12'h000, nv_baud});
    note(4'h5, 16'h0021);
    note(4'hB, {8'h00, fmt_in});
    fcal <= ~fcal;
    cmdx(MMSC_CMD_CAL_RELOAD, 8'h00);
    note(4'h8, fcal);
    dreq <= rnd[3:0] ^ 4'hF;
    dwr <= 1'b1;
    @(posedge clk);
    dwr <= 1'b0;
    note(4'h9, {12'h000, rnd[3:0] ^ 4'hF});
    for (int i = 0; i < 8; i++) begin
      cmdx(MMSC_CMD_MODBUS, code_t[i]);
      note(4'h4, {8'h00, code_t[i]});
      v = lo_t[i] + int'(rnd[15:0]) % (hi_t[i] - lo_t[i] + 1);
      rnd = lfsr(rnd);
      eng_chk(lo_t[i] - 1, 16'h8000);
      eng_chk(hi_t[i] + 1, 16'h7FFF);
      eng_chk(lo_t[i], lo_t[i][15:0]);
      eng_chk(hi_t[i], hi_t[i][15:0]);
      eng_chk(v, v[15:0]);
    end
    sub <= 8'h07;
    cmdx(MMSC_CMD_MODBUS, 8'h07);
    note(4'h4, 16'h001A);
    boot(1'b1, 1'b0, 1'b1);
    pro <= 1'b1;
    cmdx(MMSC_CMD_PROTO_SEL, 8'h00);
    note(4'h7, 16'h0001);
    cks <= 1'b1;
    cmdx(MMSC_CMD_CFG_SET, 8'h05);
    note(4'h7, 16'h0003);
    note(4'h6, 16'h0003);
    boot(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    summarize;
  end

  // hang guard
  initial begin
    #(25 * 20000);
    mismatches++;
    summarize;
  end
endmodule : module_mode_status_control_test
